// ==== core/eeprom_pkg.sv ====
// shared constants and state types for the two-wire eeprom link
package eeprom_pkg;
  // device-type code; value is arbitrary
  localparam logic [3:0] DEV_TYPE = 4'h6;
  localparam int ADDR_W = 15;
  localparam int PAGE_W = 6;
  localparam int PAGE_BYTES = 64;
  localparam int MASTER_ADDR_W = 16;
  // slave address byte layout
  localparam int SA_TYPE_LSB = 4;
  localparam int SA_STRAP_LSB = 2;
  localparam int SA_RW_BIT = 0;
  // byte positions inside a write frame
  localparam logic [1:0] BYTE_SLAVE = 2'h0;
  localparam logic [1:0] BYTE_AHI = 2'h1;
  localparam logic [1:0] BYTE_ALO = 2'h2;
  localparam logic [1:0] BYTE_DATA = 2'h3;
  // timing
  localparam int CLK_PERIOD_NS = 5;
  localparam int WRITE_TIME_MS = 5;
  localparam int WRITE_CYCLES = WRITE_TIME_MS * 1000000 / CLK_PERIOD_NS;
  localparam int SCL_PERIOD_NS = 160;
  localparam int SCL_QUARTER = SCL_PERIOD_NS / 4 / CLK_PERIOD_NS;
  localparam int FIFO_DEPTH = 4;

  typedef enum logic [2:0] {
    S_IDLE = 3'h0,
    S_RX = 3'h1,
    S_ACK = 3'h3,
    S_SKIP = 3'h2,
    S_BUSY = 3'h6
  } dev_state_t;

  typedef enum logic [2:0] {
    M_IDLE = 3'h0,
    M_START = 3'h1,
    M_BYTE = 3'h3,
    M_ACK = 3'h2,
    M_STOP = 3'h6
  } mst_state_t;
endpackage : eeprom_pkg

// ==== core/two_wire_if.sv ====
// two-wire link between bus master and eeprom slave
`timescale 1ns/1ps
interface two_wire_if;
  logic scl;
  logic sdaMasterOut;
  logic sdaMasterOe;
  logic sdaSlaveOut;
  logic sdaSlaveOe;
  logic sda;

  // wired-and with pull-up: any enabled low driver wins
  assign sda = !((sdaMasterOe && !sdaMasterOut) ||
                 (sdaSlaveOe && !sdaSlaveOut));

  modport master(output scl, output sdaMasterOut, output sdaMasterOe,
                 input sda);
  modport slave(input scl, input sda, output sdaSlaveOut,
                output sdaSlaveOe);
endinterface : two_wire_if

// ==== core/sync_fifo.sv ====
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/1ps
module sync_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 4
) (
  // clock, reset, enable
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic clkEn,
  // fill side
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  // drain side
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);

  logic [WIDTH-1:0] store [0:DEPTH-1];
  logic [PW-1:0] wrPtr_reg;
  logic [PW-1:0] rdPtr_reg;
  logic [CW-1:0] count_reg;
  logic [CW-1:0] count_next;
  logic push;
  logic pop;

  assign push = inValid && inReady;
  assign pop = outValid && outReady;
  assign outData = store[rdPtr_reg];

  always_comb begin
    count_next = count_reg;
    if (push && !pop) begin
      count_next = count_reg + CW'(1);
    end else if (pop && !push) begin
      count_next = count_reg - CW'(1);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (clkEn && push) begin
      store[wrPtr_reg] <= inData;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wrPtr_reg <= '0;
      rdPtr_reg <= '0;
      count_reg <= '0;
      inReady <= 1'b1;
      outValid <= 1'b0;
    end else if (clkEn) begin
      if (push) begin
        wrPtr_reg <= wrPtr_reg + PW'(1);
      end
      if (pop) begin
        rdPtr_reg <= rdPtr_reg + PW'(1);
      end
      count_reg <= count_next;
      inReady <= count_next != FULL_CNT;
      outValid <= count_next != '0;
    end
  end
endmodule : sync_fifo

// ==== core/eeprom_slave.sv ====
// eeprom slave end: start/stop, address match, page write, write cycle
// Notes on behaviour
// - sda change while scl high is start/stop
// - data changes only while scl low
// - start is sda fall, scl high
// - stop is sda rise, scl high
// - master ends each operation with stop
// - master starts only on idle bus
// - receiver pulls sda low to acknowledge
// - sda is open drain, low or released
// - top four address bits match type
// - next two bits match strap pins
// - address bit zero chooses read or write; only write (bit zero low) is matched and acknowledged here
// - acknowledge matched address on ninth clock
// - two address bytes load the pointer
// - stop after data starts programming
// - bus ignored during programming
// - page write takes up to 64 bytes
// - only six low address bits increment
// - over 64 bytes wraps and overwrites
// - written page bytes committed in one write cycle, one byte per clock
// - write cycle self-timed, about 5 ms
// - write protect high blocks array writes
// - array of 32768 or 16384 bytes
// - no address acknowledge while busy
`timescale 1ns/1ps
module eeprom_slave
  import eeprom_pkg::*;
#(
  parameter int WRITE_CYCLES_P = WRITE_CYCLES,
  parameter int ADDR_BITS = ADDR_W
) (
  // clock, reset, enable
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic clkEn,
  // two-wire link
  two_wire_if.slave link,
  // straps and protection pins
  input wire logic chipSelectStrap0,
  input wire logic chipSelectStrap1,
  input wire logic writeProtect,
  // array inspection
  input wire logic [ADDR_BITS-1:0] peekAddr,
  output logic [7:0] peekData,
  output logic busy
);
  localparam int BCW = $clog2(WRITE_CYCLES_P);
  localparam logic [BCW-1:0] BUSY_LAST = BCW'(WRITE_CYCLES_P - 1);

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic [4:0] pinMeta_reg;
  logic [4:0] pinSync_reg;
  logic sclPrev_reg;
  logic sdaPrev_reg;
  logic sclS;
  logic sdaS;
  logic [1:0] strapS;
  logic wpS;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pinMeta_reg <= 5'h03;
      pinSync_reg <= 5'h03;
      sclPrev_reg <= 1'b1;
      sdaPrev_reg <= 1'b1;
    end else if (clkEn) begin
      pinMeta_reg <= {writeProtect, chipSelectStrap1, chipSelectStrap0,
                      link.sda, link.scl};
      pinSync_reg <= pinMeta_reg;
      sclPrev_reg <= pinSync_reg[0];
      sdaPrev_reg <= pinSync_reg[1];
    end
  end

  assign sclS = pinSync_reg[0];
  assign sdaS = pinSync_reg[1];
  assign strapS = pinSync_reg[3:2];
  assign wpS = pinSync_reg[4];

  ////////////////////////////////////////////////////////////////////////
  // bus conditions
  logic sclRise;
  logic sclFall;
  logic startCond;
  logic stopCond;

  assign sclRise = sclS && !sclPrev_reg;
  assign sclFall = !sclS && sclPrev_reg;
  // data is only taken on scl edges, so sda moving with scl low is harmless
  assign startCond = sclS && sclPrev_reg && sdaPrev_reg && !sdaS;
  assign stopCond = sclS && sclPrev_reg && !sdaPrev_reg && sdaS;

  ////////////////////////////////////////////////////////////////////////
  // receive state machine
  dev_state_t state_reg;
  logic [2:0] bitCnt_reg;
  logic [1:0] byteNo_reg;
  logic [7:0] shift_reg;
  logic fullByte_reg;
  logic ackPend_reg;
  logic dataSeen_reg;
  logic sdaOe_reg;
  logic [BCW-1:0] busyCnt_reg;
  logic [7:0] rxByte;
  logic gotByte;
  logic addrMatch;

  assign rxByte = {shift_reg[6:0], sdaS};
  assign gotByte = (state_reg == S_RX) && sclRise && (bitCnt_reg == 3'h7);
  assign addrMatch = (rxByte[7:SA_TYPE_LSB] == DEV_TYPE) &&
                     (rxByte[SA_STRAP_LSB+:2] == strapS) &&
                     !rxByte[SA_RW_BIT];

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_reg <= S_IDLE;
      bitCnt_reg <= '0;
      byteNo_reg <= BYTE_SLAVE;
      shift_reg <= '0;
      fullByte_reg <= 1'b0;
      ackPend_reg <= 1'b0;
      dataSeen_reg <= 1'b0;
      sdaOe_reg <= 1'b0;
      busy <= 1'b0;
    end else if (clkEn) begin
      if (state_reg == S_BUSY) begin
        // all bus activity is ignored until the cycle ends
        if (busyCnt_reg == BUSY_LAST) begin
          state_reg <= S_IDLE;
          busy <= 1'b0;
        end
      end else if (startCond) begin
        state_reg <= S_RX;
        bitCnt_reg <= '0;
        byteNo_reg <= BYTE_SLAVE;
        fullByte_reg <= 1'b0;
        dataSeen_reg <= 1'b0;
        sdaOe_reg <= 1'b0;
      end else if (stopCond) begin
        sdaOe_reg <= 1'b0;
        fullByte_reg <= 1'b0;
        if (dataSeen_reg) begin
          state_reg <= S_BUSY;
          busy <= 1'b1;
        end else begin
          state_reg <= S_IDLE;
        end
      end else begin
        unique case (state_reg)
          S_RX: begin
            if (sclRise && !fullByte_reg) begin
              shift_reg <= rxByte;
              bitCnt_reg <= bitCnt_reg + 3'h1;
            end
            if (gotByte) begin
              fullByte_reg <= 1'b1;
              ackPend_reg <= (byteNo_reg == BYTE_SLAVE) ? addrMatch : 1'b1;
              if (byteNo_reg == BYTE_DATA) begin
                dataSeen_reg <= 1'b1;
              end
            end
            if (sclFall && fullByte_reg) begin
              fullByte_reg <= 1'b0;
              if (ackPend_reg) begin
                sdaOe_reg <= 1'b1;
                state_reg <= S_ACK;
              end else begin
                state_reg <= S_SKIP;
              end
            end
          end
          S_ACK: begin
            if (sclFall) begin
              sdaOe_reg <= 1'b0;
              state_reg <= S_RX;
              if (byteNo_reg != BYTE_DATA) begin
                byteNo_reg <= byteNo_reg + 2'h1;
              end
            end
          end
          S_IDLE, S_SKIP: begin
          end
          default: state_reg <= S_IDLE;
        endcase
      end
    end
  end

  // only pulls low, never drives high
  assign link.sdaSlaveOut = 1'b0;
  assign link.sdaSlaveOe = sdaOe_reg;

  ////////////////////////////////////////////////////////////////////////
  // address pointer and page buffer
  logic [ADDR_BITS-1:0] ptr_reg;
  logic [7:0] pageBuf [0:PAGE_BYTES-1];
  logic [PAGE_BYTES-1:0] pageMask_reg;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ptr_reg <= '0;
      pageMask_reg <= '0;
    end else if (clkEn && state_reg != S_BUSY) begin
      if (startCond) begin
        pageMask_reg <= '0;
      end else if (gotByte) begin
        unique case (byteNo_reg)
          BYTE_AHI: ptr_reg[ADDR_BITS-1:8] <= rxByte[ADDR_BITS-9:0];
          BYTE_ALO: ptr_reg[7:0] <= rxByte;
          BYTE_DATA: begin
            // wrap within the page; later bytes overwrite earlier ones
            pageMask_reg[ptr_reg[PAGE_W-1:0]] <= 1'b1;
            ptr_reg[PAGE_W-1:0] <= ptr_reg[PAGE_W-1:0] + 6'h01;
          end
          BYTE_SLAVE: begin
          end
        endcase
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (clkEn && state_reg != S_BUSY && !startCond && gotByte &&
        byteNo_reg == BYTE_DATA) begin
      pageBuf[ptr_reg[PAGE_W-1:0]] <= rxByte;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // self-timed write cycle and array commit
  logic [7:0] mem [0:(1<<ADDR_BITS)-1];
  logic [PAGE_W:0] commitIdx_reg;
  logic commitNow;

  // commit walks the page in the first cycles of the busy window
  assign commitNow = (state_reg == S_BUSY) && !commitIdx_reg[PAGE_W];

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      busyCnt_reg <= '0;
      commitIdx_reg <= '0;
    end else if (clkEn) begin
      if (state_reg == S_BUSY) begin
        busyCnt_reg <= busyCnt_reg + BCW'(1);
        if (commitNow) begin
          commitIdx_reg <= commitIdx_reg + 7'h01;
        end
      end else begin
        busyCnt_reg <= '0;
        commitIdx_reg <= '0;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (clkEn && commitNow && pageMask_reg[commitIdx_reg[PAGE_W-1:0]] &&
        !wpS) begin
      mem[{ptr_reg[ADDR_BITS-1:PAGE_W], commitIdx_reg[PAGE_W-1:0]}] <=
        pageBuf[commitIdx_reg[PAGE_W-1:0]];
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      peekData <= '0;
    end else if (clkEn) begin
      peekData <= mem[peekAddr];
    end
  end
endmodule : eeprom_slave

// ==== core/eeprom_master.sv ====
// bus master end: start, address, pointer, fifo-fed data, stop
`timescale 1ns/1ps
module eeprom_master
  import eeprom_pkg::*;
#(
  parameter int QUARTER = SCL_QUARTER,
  parameter int DEPTH = FIFO_DEPTH
) (
  // clock, reset, enable
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic clkEn,
  // two-wire link
  two_wire_if.master link,
  // write command
  input wire logic cmdValid,
  output logic cmdReady,
  input wire logic [1:0] cmdSel,
  input wire logic [MASTER_ADDR_W-1:0] cmdAddr,
  // write data stream
  input wire logic wrValid,
  output logic wrReady,
  input wire logic [7:0] wrData,
  input wire logic wrLast,
  // completion
  output logic doneValid,
  output logic doneNack
);
  localparam int QW = $clog2(QUARTER + 1);
  localparam logic [QW-1:0] Q_LAST = QW'(QUARTER - 1);

  logic fifoValid;
  logic fifoPop;
  logic [8:0] fifoData;

  sync_fifo #(.WIDTH(9), .DEPTH(DEPTH)) dataFifo (
    .ref_clk(ref_clk),
    .rst(rst),
    .clkEn(clkEn),
    .inValid(wrValid),
    .inReady(wrReady),
    .inData({wrLast, wrData}),
    .outValid(fifoValid),
    .outReady(fifoPop),
    .outData(fifoData)
  );

  ////////////////////////////////////////////////////////////////////////
  // sda sampler and quarter-bit tick
  logic sdaMeta_reg;
  logic sdaSync_reg;
  logic [QW-1:0] qCnt_reg;
  logic tick;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sdaMeta_reg <= 1'b1;
      sdaSync_reg <= 1'b1;
      qCnt_reg <= '0;
    end else if (clkEn) begin
      sdaMeta_reg <= link.sda;
      sdaSync_reg <= sdaMeta_reg;
      qCnt_reg <= (qCnt_reg == Q_LAST) ? '0 : qCnt_reg + QW'(1);
    end
  end

  assign tick = qCnt_reg == Q_LAST;

  ////////////////////////////////////////////////////////////////////////
  // frame sequencer
  mst_state_t state_reg;
  logic [1:0] phase_reg;
  logic [2:0] bitCnt_reg;
  logic [1:0] byteNo_reg;
  logic [7:0] txByte_reg;
  logic [MASTER_ADDR_W-1:0] addr_reg;
  logic lastSent_reg;
  logic ackSeen_reg;
  logic scl_reg;
  logic sdaLow_reg;
  logic stall;

  // stall in the ack clock, scl held high, until the fifo has the next byte
  assign stall = (state_reg == M_ACK) && (phase_reg == 2'h3) &&
                 ackSeen_reg && !lastSent_reg &&
                 (byteNo_reg == BYTE_ALO) && !fifoValid;
  assign fifoPop = clkEn && tick && (state_reg == M_ACK) &&
                   (phase_reg == 2'h3) && ackSeen_reg && !lastSent_reg &&
                   (byteNo_reg == BYTE_ALO) && fifoValid;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_reg <= M_IDLE;
      phase_reg <= '0;
      bitCnt_reg <= '0;
      byteNo_reg <= BYTE_SLAVE;
      txByte_reg <= '0;
      addr_reg <= '0;
      lastSent_reg <= 1'b0;
      ackSeen_reg <= 1'b0;
      scl_reg <= 1'b1;
      sdaLow_reg <= 1'b0;
      cmdReady <= 1'b1;
      doneValid <= 1'b0;
      doneNack <= 1'b0;
    end else if (clkEn) begin
      doneValid <= 1'b0;
      if (state_reg == M_IDLE) begin
        if (cmdValid && cmdReady) begin
          cmdReady <= 1'b0;
          addr_reg <= cmdAddr;
          txByte_reg <= {DEV_TYPE, cmdSel, 1'b0, 1'b0};
          byteNo_reg <= BYTE_SLAVE;
          lastSent_reg <= 1'b0;
          phase_reg <= '0;
          state_reg <= M_START;
        end
      end else if (tick && !stall) begin
        phase_reg <= phase_reg + 2'h1;
        unique case (state_reg)
          M_START: begin
            if (phase_reg == 2'h0) sdaLow_reg <= 1'b1;
            if (phase_reg == 2'h1) begin
              scl_reg <= 1'b0;
              phase_reg <= '0;
              bitCnt_reg <= '0;
              state_reg <= M_BYTE;
            end
          end
          M_BYTE: begin
            if (phase_reg == 2'h0) sdaLow_reg <= !txByte_reg[7];
            if (phase_reg == 2'h1) scl_reg <= 1'b1;
            if (phase_reg == 2'h3) begin
              scl_reg <= 1'b0;
              txByte_reg <= {txByte_reg[6:0], 1'b0};
              bitCnt_reg <= bitCnt_reg + 3'h1;
              if (bitCnt_reg == 3'h7) state_reg <= M_ACK;
            end
          end
          M_ACK: begin
            if (phase_reg == 2'h0) sdaLow_reg <= 1'b0;
            if (phase_reg == 2'h1) scl_reg <= 1'b1;
            if (phase_reg == 2'h2) ackSeen_reg <= !sdaSync_reg;
            if (phase_reg == 2'h3) begin
              scl_reg <= 1'b0;
              state_reg <= M_BYTE;
              if (!ackSeen_reg || lastSent_reg) begin
                doneNack <= !ackSeen_reg;
                state_reg <= M_STOP;
              end else begin
                unique case (byteNo_reg)
                  BYTE_SLAVE: txByte_reg <= addr_reg[15:8];
                  BYTE_AHI: txByte_reg <= addr_reg[7:0];
                  default: begin
                    txByte_reg <= fifoData[7:0];
                    lastSent_reg <= fifoData[8];
                  end
                endcase
                if (byteNo_reg != BYTE_ALO) byteNo_reg <= byteNo_reg + 2'h1;
              end
            end
          end
          M_STOP: begin
            if (phase_reg == 2'h0) sdaLow_reg <= 1'b1;
            if (phase_reg == 2'h1) scl_reg <= 1'b1;
            if (phase_reg == 2'h2) sdaLow_reg <= 1'b0;
            if (phase_reg == 2'h3) begin
              state_reg <= M_IDLE;
              doneValid <= 1'b1;
              cmdReady <= 1'b1;
            end
          end
          default: state_reg <= M_IDLE;
        endcase
      end
    end
  end

  assign link.scl = scl_reg;
  assign link.sdaMasterOut = 1'b0;
  assign link.sdaMasterOe = sdaLow_reg;
endmodule : eeprom_master

// ==== bench/eeprom_asserts.sv ====
// concurrent checks on the two-wire link and the slave write cycle
`timescale 1ns/1ps
module eeprom_asserts #(
  parameter int WRITE_CYCLES_P = 2000
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // wire signals
  input wire logic scl,
  input wire logic sda,
  input wire logic sdaMasterOe,
  input wire logic sdaSlaveOut,
  input wire logic sdaSlaveOe,
  // slave status
  input wire logic busy
);
  logic sclQ;
  logic sdaQ;
  logic inFrame;
  logic [3:0] stopAge;
  int busyCnt;
  logic startEv;
  logic stopEv;

  ////////////////////////////////////////////////////////////////////////////
  // raw edge watch, reset to idle bus so release gives no false start
  assign startEv = sclQ && scl && sdaQ && !sda;
  assign stopEv = sclQ && scl && !sdaQ && sda;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sclQ <= 1'b1;
      sdaQ <= 1'b1;
    end else begin
      sclQ <= scl;
      sdaQ <= sda;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) inFrame <= 1'b0;
    else if (startEv) inFrame <= 1'b1;
    else if (stopEv) inFrame <= 1'b0;
  end

  // saturates so an old stop never looks recent
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) stopAge <= 4'hf;
    else if (stopEv) stopAge <= 4'h0;
    else if (stopAge != 4'hf) stopAge <= stopAge + 4'h1;
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) busyCnt <= 0;
    else if (busy) busyCnt <= busyCnt + 1;
    else busyCnt <= 0;
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  slave_drain_only_a: assert property (sdaSlaveOut == 1'b0)
    else $error("slave drives sda high");
  // master may move sda under a high scl only to open or close a frame
  master_sda_move_a: assert property (
    $changed(sdaMasterOe) && scl |-> !inFrame || stopEv)
    else $error("master moved sda while scl high inside a frame");
  slave_scl_low_a: assert property ($changed(sdaSlaveOe) |-> !scl)
    else $error("slave moved sda while scl high");
  ack_length_a: assert property ($rose(sdaSlaveOe) |->
    sdaSlaveOe[*8] ##[20:28] $fell(sdaSlaveOe))
    else $error("acknowledge not one clock period long");
  ack_after_start_a: assert property (sdaSlaveOe |-> inFrame)
    else $error("slave answered outside a frame");
  busy_quiet_a: assert property (busy |-> !sdaSlaveOe)
    else $error("slave drove sda while programming");
  busy_after_stop_a: assert property ($rose(busy) |-> stopAge < 4'h8)
    else $error("write cycle began without a stop");
  busy_length_a: assert property ($fell(busy) |->
    busyCnt >= WRITE_CYCLES_P - 1 && busyCnt <= WRITE_CYCLES_P + 1)
    else $error("write cycle length wrong");
  busy_bound_a: assert property (busyCnt <= WRITE_CYCLES_P + 1)
    else $error("write cycle overran");
endmodule : eeprom_asserts

// ==== bench/tb.sv ====
// testbench: master and slave ends joined, write frames driven through
`timescale 1ns/1ps
module tb;
  import eeprom_pkg::*;
  localparam int WCYC = 2000;
  logic ref_clk;
  logic rst;
  logic clkEn;
  logic chipSelectStrap0;
  logic chipSelectStrap1;
  logic writeProtect;
  logic [ADDR_W-1:0] peekAddr;
  logic [7:0] peekData;
  logic busy;
  logic cmdValid;
  logic cmdReady;
  logic [1:0] cmdSel;
  logic [MASTER_ADDR_W-1:0] cmdAddr;
  logic wrValid;
  logic wrReady;
  logic [7:0] wrData;
  logic wrLast;
  logic doneValid;
  logic doneNack;
  int nFail;
  int cmpCount;
  logic [7:0] expPage [64];

  ////////////////////////////////////////////////////////////////////////////
  two_wire_if two_wire_if_i();
  eeprom_slave #(.WRITE_CYCLES_P(WCYC)) eeprom_slave_i(.ref_clk, .rst,
    .clkEn, .link(two_wire_if_i), .chipSelectStrap0, .chipSelectStrap1,
    .writeProtect, .peekAddr, .peekData, .busy);
  eeprom_master #(.QUARTER(8), .DEPTH(4)) eeprom_master_i(.ref_clk, .rst,
    .clkEn, .link(two_wire_if_i), .cmdValid, .cmdReady, .cmdSel, .cmdAddr,
    .wrValid, .wrReady, .wrData, .wrLast, .doneValid, .doneNack);
  eeprom_asserts #(.WRITE_CYCLES_P(WCYC)) eeprom_asserts_i(.ref_clk, .rst,
    .scl(two_wire_if_i.scl), .sda(two_wire_if_i.sda),
    .sdaMasterOe(two_wire_if_i.sdaMasterOe),
    .sdaSlaveOut(two_wire_if_i.sdaSlaveOut),
    .sdaSlaveOe(two_wire_if_i.sdaSlaveOe), .busy);

  ////////////////////////////////////////////////////////////////////////////
  task automatic stopTest;
    if (nFail == 0 && cmpCount > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : stopTest

  task automatic check(input string what, input logic [7:0] exp,
                       input logic [7:0] got);
    cmpCount++;
    if (got !== exp) begin
      nFail++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic hang(input string what);
    nFail++;
    $display("[FAIL] %s expected 1 seen timeout", what);
    stopTest();
  endtask : hang

  // valid is left high; caller lowers it after the last byte
  task automatic push(input logic [7:0] d, input logic last);
    int i;
    wrValid = 1'b1;
    wrData = d;
    wrLast = last;
    for (i = 0; i < 40000 && wrReady !== 1'b1; i++) @(negedge ref_clk);
    if (wrReady !== 1'b1) hang("wrReady");
    @(negedge ref_clk);
  endtask : push

  task automatic command(input logic [1:0] sel, input logic [15:0] addr);
    int i;
    cmdValid = 1'b1;
    cmdSel = sel;
    cmdAddr = addr;
    for (i = 0; i < 40000 && cmdReady !== 1'b1; i++) @(negedge ref_clk);
    if (cmdReady !== 1'b1) hang("cmdReady");
    @(negedge ref_clk);
    cmdValid = 1'b0;
  endtask : command

  task automatic waitDone(input logic expNack);
    int i;
    for (i = 0; i < 40000 && doneValid !== 1'b1; i++) @(negedge ref_clk);
    if (doneValid !== 1'b1) hang("doneValid");
    check("doneNack", {7'h0, expNack}, {7'h0, doneNack});
    @(negedge ref_clk);
  endtask : waitDone

  task automatic waitIdle;
    int i;
    for (i = 0; i < 3 * WCYC && busy !== 1'b0; i++) @(negedge ref_clk);
    if (busy !== 1'b0) hang("busy low");
  endtask : waitIdle

  // one cycle of read latency on the inspection port
  task automatic peek(input logic [14:0] a, input logic [7:0] exp);
    peekAddr = a;
    @(negedge ref_clk);
    check("peekData", exp, peekData);
  endtask : peek

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  initial begin
    rst = 1'b1;
    clkEn = 1'b1;
    chipSelectStrap0 = 1'b0;
    chipSelectStrap1 = 1'b1;
    writeProtect = 1'b0;
    peekAddr = '0;
    cmdValid = 1'b0;
    cmdSel = 2'h0;
    cmdAddr = 16'h0000;
    wrValid = 1'b0;
    wrData = 8'h00;
    wrLast = 1'b0;
    nFail = 0;
    cmpCount = 0;
    repeat (5) @(negedge ref_clk);
    rst = 1'b0;
    // byte write, pointer top bit must be dropped
    command(2'h2, 16'hb234);
    push(8'h3c, 1'b1);
    wrValid = 1'b0;
    waitDone(1'b0);
    check("busy", 8'h01, {7'h0, busy});
    // polling while programming gets no answer
    command(2'h2, 16'h0000);
    waitDone(1'b1);
    waitIdle();
    peek(15'h3234, 8'h3c);
    // wrong strap values are not selected
    for (int s = 0; s < 4; s++) begin
      if (s != 2) begin
        command(s[1:0], 16'h0000);
        waitDone(1'b1);
      end
    end
    check("busy", 8'h00, {7'h0, busy});
    // protected array keeps its old byte
    writeProtect = 1'b1;
    command(2'h2, 16'h3234);
    push(8'hc5, 1'b1);
    wrValid = 1'b0;
    waitDone(1'b0);
    waitIdle();
    peek(15'h3234, 8'h3c);
    writeProtect = 1'b0;
    // page write of 66 bytes from offset 62: wraps, last two overwrite
    for (int k = 0; k < 66; k++) expPage[(62 + k) % 64] = k[7:0] ^ 8'ha5;
    for (int k = 0; k < 4; k++) push(k[7:0] ^ 8'ha5, 1'b0);
    check("wrReady", 8'h00, {7'h0, wrReady});
    wrValid = 1'b0;
    command(2'h2, 16'h00fe);
    for (int k = 4; k < 66; k++) push(k[7:0] ^ 8'ha5, k == 65);
    wrValid = 1'b0;
    waitDone(1'b0);
    waitIdle();
    for (int k = 0; k < 64; k++) peek(15'h00c0 + 15'(k), expPage[k]);
    stopTest();
  end
endmodule : tb
